/* logic/rct_countdown_trim.sv */
// Countdown timer, frequency output selection, INT selection and trim register of the clock.
// ****************************************
// Operation
// ****************************************
module rct_countdown_trim #(
    parameter bit LowFreqXtal = 1'b0
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // Oscillator pin
    input  wire logic                 oscIn,
    // Register access
    input  wire rct_pkg::rct_reg_wr_s regWr,
    input  wire logic [4:0]           regRdAddr,
    output logic      [7:0]           regRdData,
    // Alarm flag from the alarm logic
    input  wire logic                 alarmIrq,
    // Outputs to pins and the rest of the clock
    output logic                      intOutN,
    output logic                      clk32kOut,
    output logic                      countdownFlag,
    output logic                      secTick,
    output logic      [5:0]           secondsCount
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic                  oscMeta;
        logic                  oscSync;
        logic                  oscDly;
        logic                  oscTick;
        logic                  cdEnable;
        logic                  freqEnable;
        rct_pkg::rct_int_sel_e intSel;
        rct_pkg::rct_freq_e    freqCode;
        rct_pkg::rct_cd_src_e  cdSrc;
        logic                  cdFlag;
        logic [6:0]            trim;
        logic                  trimActive;
        logic [7:0]            cdCount;
        logic                  cdRun;
        logic [7:0]            rdData;
        logic                  intN;
    } rct_main_state_s;

    rct_main_state_s stateQ;
    rct_main_state_s stateD;

    logic [15:0] divCount;
    logic        preSecTick;
    logic [5:0]  preSeconds;
    logic [3:0]  secDiv;

    rct_prescaler #(
        .LowFreqXtal (LowFreqXtal)
    ) u_prescaler (
        .mclk        (mclk),
        .rst         (rst),
        .oscTick     (stateQ.oscTick),
        .trimActive  (stateQ.trimActive),
        .trimCode    (stateQ.trim),
        .divCount    (divCount),
        .secTick     (preSecTick),
        .seconds     (preSeconds),
        .secDiv      (secDiv)
    );

    // Tick when the low bits of the divider are all ones on an oscillator pulse.
    function automatic logic wrapTick(input logic [15:0] cnt, input logic [15:0] mask,
                                      input logic osc);
        wrapTick = osc && ((cnt & mask) == mask);
    endfunction

    function automatic logic regHit(input rct_pkg::rct_reg_wr_s wr, input logic [4:0] addr);
        regHit = wr.en && (wr.addr == addr);
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    logic cdTick;
    logic freqWave;

    always_comb begin
        stateD         = stateQ;
        stateD.oscMeta = oscIn;
        stateD.oscSync = stateQ.oscMeta;
        stateD.oscDly  = stateQ.oscSync;
        stateD.oscTick = stateQ.oscSync && !stateQ.oscDly;

        case (stateQ.cdSrc)
            rct_pkg::CD_SRC_4096HZ: cdTick = wrapTick(divCount, rct_pkg::TICK_4096_MASK,
                                                      stateQ.oscTick);
            rct_pkg::CD_SRC_64HZ:   cdTick = wrapTick(divCount, rct_pkg::TICK_64_MASK,
                                                      stateQ.oscTick);
            rct_pkg::CD_SRC_1HZ:    cdTick = preSecTick;
            rct_pkg::CD_SRC_1MIN:   cdTick = preSecTick && (preSeconds == 6'h00);
            default:                cdTick = 1'b0;
        endcase

        // The divided rates come from the trimmed divider, so they carry the trim.
        case (stateQ.freqCode)
            rct_pkg::FREQ_OFF:     freqWave = 1'b0;
            rct_pkg::FREQ_32768HZ: freqWave = stateQ.oscSync;
            rct_pkg::FREQ_4096HZ:  freqWave = divCount[2];
            rct_pkg::FREQ_1024HZ:  freqWave = divCount[4];
            rct_pkg::FREQ_64HZ:    freqWave = divCount[8];
            rct_pkg::FREQ_32HZ:    freqWave = divCount[9];
            rct_pkg::FREQ_16HZ:    freqWave = divCount[10];
            rct_pkg::FREQ_8HZ:     freqWave = divCount[11];
            rct_pkg::FREQ_4HZ:     freqWave = divCount[12];
            rct_pkg::FREQ_2HZ:     freqWave = divCount[13];
            rct_pkg::FREQ_1_2HZ:   freqWave = secDiv[0];
            rct_pkg::FREQ_1_4HZ:   freqWave = secDiv[1];
            rct_pkg::FREQ_1_8HZ:   freqWave = secDiv[2];
            rct_pkg::FREQ_1_16HZ:  freqWave = secDiv[3];
            rct_pkg::FREQ_1S:      freqWave = (divCount[15:8] == 8'h00);
            default:               freqWave = 1'b0;
        endcase

        if (regHit(regWr, rct_pkg::ADDR_CTRL2)) begin
            stateD.freqEnable = regWr.data[rct_pkg::CTRL2_FREQ_EN_BIT];
            stateD.cdEnable   = regWr.data[rct_pkg::CTRL2_CD_EN_BIT];
            stateD.intSel     = rct_pkg::rct_int_sel_e'(
                                regWr.data[rct_pkg::CTRL2_INT_SEL_LSB +: 2]);
        end
        if (regHit(regWr, rct_pkg::ADDR_CTRL3)) begin
            stateD.freqCode = rct_pkg::rct_freq_e'(regWr.data[rct_pkg::CTRL3_FREQ_LSB +: 4]);
            stateD.cdSrc    = rct_pkg::rct_cd_src_e'(
                              regWr.data[rct_pkg::CTRL3_CD_SRC_LSB +: 2]);
        end
        if (regHit(regWr, rct_pkg::ADDR_TRIM)) begin
            stateD.trim       = regWr.data[6:0];
            stateD.trimActive = 1'b1;
        end

        // Writing zero to the flag clears it; writing one leaves it alone.
        if (regHit(regWr, rct_pkg::ADDR_CTRL1) &&
            !regWr.data[rct_pkg::CTRL1_CD_FLAG_BIT]) begin
            stateD.cdFlag = 1'b0;
        end

        // A loaded zero wraps to 255 on the first tick, giving 256 ticks to the flag.
        if (regHit(regWr, rct_pkg::ADDR_CDOWN) && stateQ.cdEnable) begin
            stateD.cdCount = regWr.data;
            stateD.cdRun   = 1'b1;
        end else if (stateQ.cdRun && !stateQ.cdEnable) begin
            stateD.cdRun = 1'b0;
        end else if (stateQ.cdRun && cdTick) begin
            stateD.cdCount = stateQ.cdCount - 8'h01;
            if (stateQ.cdCount == 8'h01) begin
                stateD.cdRun  = 1'b0;
                stateD.cdFlag = 1'b1;
            end
        end

        stateD.rdData = 8'h00;
        case (regRdAddr)
            rct_pkg::ADDR_CTRL1: stateD.rdData[rct_pkg::CTRL1_CD_FLAG_BIT] = stateQ.cdFlag;
            rct_pkg::ADDR_CTRL2: begin
                stateD.rdData[rct_pkg::CTRL2_FREQ_EN_BIT]     = stateQ.freqEnable;
                stateD.rdData[rct_pkg::CTRL2_CD_EN_BIT]       = stateQ.cdEnable;
                stateD.rdData[rct_pkg::CTRL2_INT_SEL_LSB +: 2] = stateQ.intSel;
            end
            rct_pkg::ADDR_CTRL3: begin
                stateD.rdData[rct_pkg::CTRL3_FREQ_LSB +: 4]   = stateQ.freqCode;
                stateD.rdData[rct_pkg::CTRL3_CD_SRC_LSB +: 2] = stateQ.cdSrc;
            end
            rct_pkg::ADDR_TRIM:  stateD.rdData = {1'b0, stateQ.trim};
            rct_pkg::ADDR_CDOWN: stateD.rdData = stateQ.cdCount;
            default:             stateD.rdData = 8'h00;
        endcase

        case (stateQ.intSel)
            rct_pkg::INT_SEL_OFF:   stateD.intN = 1'b1;
            rct_pkg::INT_SEL_ALARM: stateD.intN = !alarmIrq;
            rct_pkg::INT_SEL_FREQ:  stateD.intN = !(stateQ.freqEnable && freqWave);
            rct_pkg::INT_SEL_CDOWN: stateD.intN = !(stateQ.cdEnable && stateQ.cdFlag);
            default:                stateD.intN = 1'b1;
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stateQ          <= '0;
            stateQ.intN     <= 1'b1;
            stateQ.trim     <= rct_pkg::TRIM_RST;
            stateQ.cdCount  <= rct_pkg::CDOWN_RST;
            stateQ.freqCode <= rct_pkg::rct_freq_e'(rct_pkg::FREQ_CODE_RST);
        end else begin
            stateQ <= stateD;
        end
    end

    assign regRdData     = stateQ.rdData;
    assign intOutN       = stateQ.intN;
    assign clk32kOut     = stateQ.oscSync;
    assign countdownFlag = stateQ.cdFlag;
    assign secTick       = preSecTick;
    assign secondsCount  = preSeconds;

endmodule

/* logic/rct_pkg.sv */
// Package with offsets, field positions, reset values and encodings of the countdown/trim block.
package rct_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [4:0] ADDR_CTRL1 = 5'h0F;
    localparam logic [4:0] ADDR_CTRL2 = 5'h10;
    localparam logic [4:0] ADDR_CTRL3 = 5'h11;
    localparam logic [4:0] ADDR_TRIM  = 5'h12;
    localparam logic [4:0] ADDR_CDOWN = 5'h13;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL1_CD_FLAG_BIT  = 2;
    localparam int CTRL2_FREQ_EN_BIT  = 1;
    localparam int CTRL2_CD_EN_BIT    = 2;
    localparam int CTRL2_INT_SEL_LSB  = 4;
    localparam int CTRL3_FREQ_LSB     = 0;
    localparam int CTRL3_CD_SRC_LSB   = 4;
    localparam int TRIM_SIGN_BIT      = 6;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [6:0] TRIM_RST      = 7'h00;
    localparam logic [7:0] CDOWN_RST     = 8'h00;
    localparam logic [3:0] FREQ_CODE_RST = 4'h0;

    // ****************************************
    // Counts of oscillator pulses and seconds
    // ****************************************
    localparam logic [15:0] SEC_PULSES_32K768 = 16'h8000;
    localparam logic [15:0] SEC_PULSES_32K000 = 16'h7D00;
    localparam logic [5:0]  SEC_TRIM_A        = 6'h00;
    localparam logic [5:0]  SEC_TRIM_B        = 6'h14;
    localparam logic [5:0]  SEC_TRIM_C        = 6'h28;
    localparam logic [5:0]  SEC_LAST          = 6'h3B;
    localparam logic [15:0] TICK_4096_MASK    = 16'h0007;
    localparam logic [15:0] TICK_64_MASK      = 16'h01FF;

    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [1:0] {
        CD_SRC_4096HZ = 2'b00,
        CD_SRC_64HZ   = 2'b01,
        CD_SRC_1HZ    = 2'b10,
        CD_SRC_1MIN   = 2'b11
    } rct_cd_src_e;

    typedef enum logic [1:0] {
        INT_SEL_OFF   = 2'b00,
        INT_SEL_ALARM = 2'b01,
        INT_SEL_FREQ  = 2'b10,
        INT_SEL_CDOWN = 2'b11
    } rct_int_sel_e;

    typedef enum logic [3:0] {
        FREQ_OFF     = 4'b0000,
        FREQ_32768HZ = 4'b0001,
        FREQ_4096HZ  = 4'b0010,
        FREQ_1024HZ  = 4'b0011,
        FREQ_64HZ    = 4'b0100,
        FREQ_32HZ    = 4'b0101,
        FREQ_16HZ    = 4'b0110,
        FREQ_8HZ     = 4'b0111,
        FREQ_4HZ     = 4'b1000,
        FREQ_2HZ     = 4'b1001,
        FREQ_1_2HZ   = 4'b1010,
        FREQ_1_4HZ   = 4'b1100,
        FREQ_1_8HZ   = 4'b1101,
        FREQ_1_16HZ  = 4'b1110,
        FREQ_1S      = 4'b1111
    } rct_freq_e;

    typedef struct packed {
        logic       en;
        logic [4:0] addr;
        logic [7:0] data;
    } rct_reg_wr_s;

endpackage

/* logic/rct_prescaler.sv */
// Trimmed one-second prescaler and seconds counter.
module rct_prescaler #(
    parameter bit LowFreqXtal = 1'b0
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Oscillator pulse and trim setting
    input  wire logic        oscTick,
    input  wire logic        trimActive,
    input  wire logic [6:0]  trimCode,
    // Time base
    output logic      [15:0] divCount,
    output logic             secTick,
    output logic      [5:0]  seconds,
    output logic      [3:0]  secDiv
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [5:0]  sec;
        logic [3:0]  secDiv;
        logic        secTick;
    } rct_pre_state_s;

    rct_pre_state_s stateQ;
    rct_pre_state_s stateD;

    localparam logic [15:0] BASE_PULSES = LowFreqXtal ? rct_pkg::SEC_PULSES_32K000
                                                      : rct_pkg::SEC_PULSES_32K768;

    logic        adjSecond;
    logic [5:0]  mag;
    logic [15:0] period;

    always_comb begin
        mag       = trimCode[5:0];
        adjSecond = (stateQ.sec == rct_pkg::SEC_TRIM_A) ||
                    (stateQ.sec == rct_pkg::SEC_TRIM_B) ||
                    (stateQ.sec == rct_pkg::SEC_TRIM_C);
        period    = BASE_PULSES;
        if (trimActive && adjSecond && (mag[5:1] != 5'h00)) begin
            if (!trimCode[rct_pkg::TRIM_SIGN_BIT]) begin
                period = BASE_PULSES + {9'h000, mag - 6'h01, 1'b0};
            end else begin
                period = BASE_PULSES - {8'h00, {1'b0, ~mag} + 7'h01, 1'b0};
            end
        end
    end

    always_comb begin
        stateD         = stateQ;
        stateD.secTick = 1'b0;
        if (oscTick) begin
            if (stateQ.cnt == period - 16'h0001) begin
                stateD.cnt     = 16'h0000;
                stateD.secTick = 1'b1;
                stateD.secDiv  = stateQ.secDiv + 4'h1;
                stateD.sec     = (stateQ.sec == rct_pkg::SEC_LAST) ? 6'h00
                                                                   : stateQ.sec + 6'h01;
            end else begin
                stateD.cnt = stateQ.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stateQ <= '0;
        end else begin
            stateQ <= stateD;
        end
    end

    assign divCount = stateQ.cnt;
    assign secTick  = stateQ.secTick;
    assign seconds  = stateQ.sec;
    assign secDiv   = stateQ.secDiv;

endmodule

/* tb/rct_countdown_trim_checker.sv */
// Port-level assertions for the countdown, INT select and trim block.
module rct_countdown_trim_checker #(
    parameter bit LowFreqXtal = 1'b0
) (
    // Clock and reset
    input wire logic                 mclk,
    input wire logic                 rst,
    // Inputs of the block
    input wire logic                 oscIn,
    input wire rct_pkg::rct_reg_wr_s regWr,
    input wire logic [4:0]           regRdAddr,
    input wire logic                 alarmIrq,
    // Outputs of the block
    input wire logic [7:0]           regRdData,
    input wire logic                 intOutN,
    input wire logic                 clk32kOut,
    input wire logic                 countdownFlag,
    input wire logic                 secTick,
    input wire logic [5:0]           secondsCount
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Control two mirror
    // ****************************************
    // The INT select and countdown enable are not visible at the ports, so they are rebuilt here.
    logic [7:0] ctrl2_q;
    logic [1:0] intSel;
    logic       cdEn;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl2_q <= 8'h00;
        end else if (regWr.en && regWr.addr == rct_pkg::ADDR_CTRL2) begin
            ctrl2_q <= regWr.data;
        end
    end
    assign intSel = ctrl2_q[5:4];
    assign cdEn   = ctrl2_q[rct_pkg::CTRL2_CD_EN_BIT];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ****************************************
    // Assertions
    // ****************************************
    a_flag_holds_set: assert property (countdownFlag && !(regWr.en && regWr.data[2] == 1'b0
        && regWr.addr == rct_pkg::ADDR_CTRL1) |=> countdownFlag)
        else $error("countdown flag dropped without a clearing write");
    a_flag_needs_enable: assert property (!cdEn && !countdownFlag |=> !countdownFlag)
        else $error("countdown flag set while countdown disabled");
    a_flag_readback: assert property ($past(regRdAddr) == rct_pkg::ADDR_CTRL1
        |-> regRdData[rct_pkg::CTRL1_CD_FLAG_BIT] == $past(countdownFlag))
        else $error("control one read does not show the countdown flag");
    a_trim_top_zero: assert property ($past(regRdAddr) == rct_pkg::ADDR_TRIM |-> !regRdData[7])
        else $error("trim register top bit reads one");
    a_raw_clk_follows: assert property ($rose(oscIn) |-> ##[1:4] $rose(clk32kOut))
        else $error("raw clock output does not follow the oscillator");
    a_sec_count_step: assert property (secTick |-> secondsCount ==
        (($past(secondsCount) == rct_pkg::SEC_LAST) ? 6'h00 : $past(secondsCount) + 6'h01))
        else $error("seconds count did not step on the second tick");
    a_sec_tick_single: assert property (secTick |=> !secTick)
        else $error("second tick wider than one cycle");
    a_int_off_high: assert property (intSel == 2'b00 |=> intOutN)
        else $error("INT pin driven while output disabled");
    a_int_alarm_path: assert property (intSel == 2'b01 |=> intOutN == !$past(alarmIrq))
        else $error("INT pin does not follow the alarm flag");
    a_int_countdown_path: assert property (intSel == 2'b11 && cdEn
        |=> intOutN == !$past(countdownFlag))
        else $error("INT pin does not follow the countdown flag");
endmodule

bind rct_countdown_trim rct_countdown_trim_checker #(.LowFreqXtal(LowFreqXtal)) chk_u (
    .mclk(mclk), .rst(rst), .oscIn(oscIn), .regWr(regWr), .regRdAddr(regRdAddr),
    .alarmIrq(alarmIrq), .regRdData(regRdData), .intOutN(intOutN), .clk32kOut(clk32kOut),
    .countdownFlag(countdownFlag), .secTick(secTick), .secondsCount(secondsCount));

/* tb/rct_host_model.sv */
// Host and crystal model: programs the block's registers and drives its oscillator pin.
module rct_host_model (
    // Clock
    input  wire logic            mclk,
    // Register access
    output rct_pkg::rct_reg_wr_s regWr,
    output logic [4:0]           regRdAddr,
    input  wire logic [7:0]      regRdData,
    // Oscillator pin
    output logic                 oscIn
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [2:0] oscCnt;

    initial begin
        regWr = '0;
        regRdAddr = 5'h00;
        oscIn = 1'b0;
        oscCnt = 3'h0;
    end

    // Five clocks per level: far faster than a crystal, yet slow enough for the synchroniser.
    always @(posedge mclk) begin
        if (oscCnt == 3'h4) begin
            oscCnt <= 3'h0;
            oscIn <= ~oscIn;
        end else begin
            oscCnt <= oscCnt + 3'h1;
        end
    end

    task automatic wrReg(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWr <= '{en: 1'b1, addr: a, data: d};
        @(posedge mclk);
        regWr.en <= 1'b0;
    endtask

    task automatic rdReg(input logic [4:0] a, output logic [7:0] d);
        @(posedge mclk);
        regRdAddr <= a;
        @(posedge mclk);
        #1;
        d = regRdData;
    endtask

    // Seven-bit two's-complement adjustment; the byte's top bit is always sent as zero.
    function automatic logic [7:0] trimByte(input int amount);
        logic [7:0] v;
        v = 8'(amount);
        return {1'b0, v[6:0]};
    endfunction
endmodule

/* tb/rct_countdown_trim_tb_top.sv */
// Self-checking testbench of the countdown, INT select and trim block.
module rct_countdown_trim_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic                 mclk;
    logic                 rst;
    logic                 oscIn;
    logic                 alarmIrq;
    rct_pkg::rct_reg_wr_s regWr;
    logic [4:0]           regRdAddr;
    logic [7:0]           regRdData;
    logic                 intOutN;
    logic                 countdownFlag;
    logic                 clk32kOut;
    logic                 secTick;
    logic [5:0]           secondsCount;
    int                   fails = 0;
    int                   n_tests = 0;
    int                   cycles = 0;
    int                   secTicks = 0;

    rct_countdown_trim dut_u (.mclk(mclk), .rst(rst), .oscIn(oscIn), .regWr(regWr),
        .regRdAddr(regRdAddr), .regRdData(regRdData), .alarmIrq(alarmIrq), .intOutN(intOutN),
        .clk32kOut(clk32kOut), .countdownFlag(countdownFlag), .secTick(secTick),
        .secondsCount(secondsCount));
    rct_host_model host_u (.mclk(mclk), .regWr(regWr), .regRdAddr(regRdAddr),
        .regRdData(regRdData), .oscIn(oscIn));

    always #4 mclk = ~mclk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic waitFlag(input int limit, output int n);
        n = 0;
        while (countdownFlag !== 1'b1 && n < limit) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask

    task automatic rdCheck(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rdReg(a, d);
        check({8'h00, d}, {8'h00, exp});
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_countdown_fast();
        int n;
        host_u.wrReg(rct_pkg::ADDR_CTRL3, 8'h00);
        host_u.wrReg(rct_pkg::ADDR_CTRL2, 8'h34);
        host_u.wrReg(rct_pkg::ADDR_CDOWN, 8'h03);
        waitFlag(300, n);
        check(16'(n >= 160 && n <= 250), 16'h0001);
        @(posedge mclk);
        #1;
        check({15'h0, intOutN}, 16'h0000);
        rdCheck(rct_pkg::ADDR_CDOWN, 8'h00);
        rdCheck(rct_pkg::ADDR_CTRL1, 8'h04);
        host_u.wrReg(rct_pkg::ADDR_CTRL1, 8'h04);
        rdCheck(rct_pkg::ADDR_CTRL1, 8'h04);
        host_u.wrReg(rct_pkg::ADDR_CTRL1, 8'h00);
        @(posedge mclk);
        #1;
        check({15'h0, countdownFlag}, 16'h0000);
        $display("test countdown_fast done");
    endtask

    task automatic test_countdown_disabled();
        int n;
        host_u.wrReg(rct_pkg::ADDR_CTRL2, 8'h30);
        host_u.wrReg(rct_pkg::ADDR_CDOWN, 8'h05);
        waitFlag(300, n);
        check({15'h0, countdownFlag}, 16'h0000);
        check({15'h0, intOutN}, 16'h0001);
        rdCheck(rct_pkg::ADDR_CDOWN, 8'h00);
        $display("test countdown_disabled done");
    endtask

    task automatic test_countdown_slow();
        int n;
        host_u.wrReg(rct_pkg::ADDR_CTRL3, 8'h10);
        host_u.wrReg(rct_pkg::ADDR_CTRL2, 8'h34);
        host_u.wrReg(rct_pkg::ADDR_CDOWN, 8'h02);
        waitFlag(11000, n);
        check(16'(n >= 5120 && n <= 10250), 16'h0001);
        host_u.wrReg(rct_pkg::ADDR_CTRL1, 8'h00);
        $display("test countdown_slow done");
    endtask

    task automatic test_trim_reg();
        host_u.wrReg(rct_pkg::ADDR_TRIM, host_u.trimByte(-60));
        rdCheck(rct_pkg::ADDR_TRIM, 8'h44);
        host_u.wrReg(rct_pkg::ADDR_TRIM, 8'hFF);
        rdCheck(rct_pkg::ADDR_TRIM, 8'h7F);
        host_u.wrReg(rct_pkg::ADDR_TRIM, host_u.trimByte(7));
        rdCheck(rct_pkg::ADDR_TRIM, 8'h07);
        host_u.wrReg(rct_pkg::ADDR_TRIM, host_u.trimByte(1));
        rdCheck(rct_pkg::ADDR_TRIM, 8'h01);
        rdCheck(5'h1F, 8'h00);
        $display("test trim_reg done");
    endtask

    task automatic test_freq_out();
        logic [3:0] codes[4] = '{4'h0, 4'h1, 4'h2, 4'h3};
        int         lo[4] = '{0, 76, 8, 2};
        int         hi[4] = '{0, 82, 11, 3};
        int         t;
        int         r;
        logic       last;
        logic       lastRaw;
        host_u.wrReg(rct_pkg::ADDR_CTRL2, 8'h22);
        for (int k = 0; k < 4; k++) begin
            host_u.wrReg(rct_pkg::ADDR_CTRL3, {4'h0, codes[k]});
            repeat (4) @(posedge mclk);
            #1;
            last = intOutN;
            lastRaw = clk32kOut;
            t = 0;
            r = 0;
            repeat (400) begin
                @(posedge mclk);
                #1;
                t += (intOutN !== last) ? 1 : 0;
                r += (clk32kOut !== lastRaw) ? 1 : 0;
                last = intOutN;
                lastRaw = clk32kOut;
            end
            check(16'(t >= lo[k] && t <= hi[k]), 16'h0001);
            check(16'(r >= 76 && r <= 82), 16'h0001);
        end
        $display("test freq_out done");
    endtask

    task automatic test_alarm_int();
        host_u.wrReg(rct_pkg::ADDR_CTRL2, 8'h10);
        @(posedge mclk);
        alarmIrq <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check({15'h0, intOutN}, 16'h0000);
        @(posedge mclk);
        alarmIrq <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check({15'h0, intOutN}, 16'h0001);
        // Far fewer than one second of oscillator pulses have passed in the whole run.
        check({10'h000, secondsCount}, 16'h0000);
        check(16'(secTicks), 16'h0000);
        $display("test alarm_int done");
    endtask

    // ****************************************
    // Main sequence and hang guard
    // ****************************************
    // Sampled on the falling edge so the one-cycle pulse is never raced.
    always @(negedge mclk) begin
        if (secTick === 1'b1) begin
            secTicks++;
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        alarmIrq = 1'b0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        test_countdown_fast();
        test_countdown_disabled();
        test_countdown_slow();
        test_trim_reg();
        test_freq_out();
        test_alarm_int();
        tally_and_finish();
    end
endmodule
